// *** hw/dcq_dual_clock_queue.sv ***
// Dual clock queue: 512 x 18 storage with pointer, flag and output logic.
// Assumes both queue clocks are sampled inputs synchronous to clk_sys.
`timescale 1ns/100ps
module dcq_dual_clock_queue
    import dcq_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  read_pointer_reset,
    input  wire logic                  write_side_clock,
    input  wire logic                  read_side_clock,
    input  wire logic                  write_enable,
    input  wire logic [DCQ_DATA_W-1:0] write_data,
    input  wire logic                  read_enable,
    output logic      [DCQ_DATA_W-1:0] read_data,
    output logic                       empty,
    output logic                       almost_empty,
    output logic                       almost_full,
    output logic                       full,
    input  wire dcq_reg_req_s          reg_req,
    output logic      [31:0]           reg_rdata,
    output logic                       irq
);

    ////////////////////////////////////////////////////////////////////////////////////////

    logic                  wr_clk_q;
    logic                  rd_clk_q;
    logic                  wr_tick;
    logic                  rd_tick;
    logic [DCQ_PTR_W-1:0]  wr_ptr;
    logic [DCQ_PTR_W-1:0]  wr_gray;
    logic [DCQ_PTR_W-1:0]  rd_ptr;
    logic [DCQ_PTR_W-1:0]  rd_gray;
    logic [DCQ_PTR_W-1:0]  rd_gray_s1;
    logic [DCQ_PTR_W-1:0]  rd_gray_s2;
    logic [DCQ_PTR_W-1:0]  wr_gray_s1;
    logic [DCQ_PTR_W-1:0]  wr_gray_s2;
    logic [DCQ_PTR_W-1:0]  rd_seen_bin;
    logic [DCQ_PTR_W-1:0]  wr_seen_bin;
    logic [DCQ_PTR_W-1:0]  next_wr_ptr;
    logic [DCQ_PTR_W-1:0]  next_rd_ptr;
    logic [DCQ_PTR_W-1:0]  next_wr_level;
    logic [DCQ_PTR_W-1:0]  next_rd_level;
    logic                  wr_ok;
    logic                  rd_ok;
    logic [DCQ_DATA_W-1:0] mem_q;
    logic [DCQ_DATA_W-1:0] out_stage;
    dcq_out_mode_e         out_mode;
    logic [DCQ_PTR_W-1:0]  ae_thr;
    logic [DCQ_PTR_W-1:0]  af_thr;
    logic [DCQ_PTR_W-1:0]  ae_thr_eff;
    logic [DCQ_PTR_W-1:0]  af_thr_eff;
    logic [DCQ_IRQ_W-1:0]  irq_status;
    logic [DCQ_IRQ_W-1:0]  irq_enable;
    logic [DCQ_IRQ_W-1:0]  irq_event;
    logic [DCQ_IRQ_W-1:0]  irq_clear;

    // Keeps a programmed threshold inside the legal band between empty and full.
    function automatic logic [DCQ_PTR_W-1:0] clamp_thr(input logic [DCQ_PTR_W-1:0] t);
        if (t < DCQ_THR_MIN) begin
            return DCQ_THR_MIN;
        end
        if (t > DCQ_THR_MAX) begin
            return DCQ_THR_MAX;
        end
        return t;
    endfunction

    default clocking dcq_cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock edge detection.

    // Each queue clock is sampled; its rising edge becomes a one-cycle tick.
    // The samplers run through reset, so a clock already high when reset ends
    // is not mistaken for a fresh edge.
    always_ff @(posedge clk_sys) begin
        wr_clk_q <= write_side_clock;
        rd_clk_q <= read_side_clock;
    end

    assign wr_tick = write_side_clock & ~wr_clk_q;
    assign rd_tick = read_side_clock & ~rd_clk_q;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Write side.

    // A word is stored only on a write tick with enable high and room left.
    assign wr_ok         = wr_tick & write_enable & ~full;
    assign next_wr_ptr   = wr_ok ? wr_ptr + DCQ_PTR_ONE : wr_ptr;
    assign rd_seen_bin   = dcq_gray2bin(rd_gray_s2);
    assign next_wr_level = next_wr_ptr - rd_seen_bin;
    assign af_thr_eff    = clamp_thr(af_thr);

    // Write pointer kept in binary and gray; only the gray copy crosses over.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr  <= DCQ_PTR_ZERO;
            wr_gray <= DCQ_PTR_ZERO;
        end else if (wr_ok) begin
            wr_ptr  <= next_wr_ptr;
            wr_gray <= next_wr_ptr ^ (next_wr_ptr >> 1);
        end
    end

    // Read pointer brought into the write side over two write ticks.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_gray_s1 <= DCQ_PTR_ZERO;
            rd_gray_s2 <= DCQ_PTR_ZERO;
        end else if (wr_tick) begin
            rd_gray_s1 <= rd_gray;
            rd_gray_s2 <= rd_gray_s1;
        end
    end

    // Full flags use the post-write level, so they rise on the storing edge,
    // but only fall once a read has crossed the two write-side stages.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            full        <= 1'b0;
            almost_full <= 1'b0;
        end else if (wr_tick) begin
            full        <= (next_wr_level == DCQ_FULL_LEVEL);
            almost_full <= (next_wr_level >= af_thr_eff);
        end
    end

    dcq_ram u_ram (
        .clk_sys (clk_sys),
        .wr_en   (wr_ok),
        .wr_addr (wr_ptr[DCQ_ADDR_W-1:0]),
        .wr_data (write_data),
        .rd_addr (rd_ptr[DCQ_ADDR_W-1:0]),
        .rd_data (mem_q)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read side.

    // Reads while empty are dropped, so the delivered sequence never breaks.
    assign rd_ok         = rd_tick & read_enable & ~empty;
    assign next_rd_ptr   = rd_ok ? rd_ptr + DCQ_PTR_ONE : rd_ptr;
    assign wr_seen_bin   = dcq_gray2bin(wr_gray_s2);
    assign next_rd_level = wr_seen_bin - next_rd_ptr;
    assign ae_thr_eff    = clamp_thr(ae_thr);

    // Read pointer; the separate pointer reset rewinds only this side.
    always_ff @(posedge clk_sys) begin
        if (rst || read_pointer_reset) begin
            rd_ptr  <= DCQ_PTR_ZERO;
            rd_gray <= DCQ_PTR_ZERO;
        end else if (rd_ok) begin
            rd_ptr  <= next_rd_ptr;
            rd_gray <= next_rd_ptr ^ (next_rd_ptr >> 1);
        end
    end

    // Write pointer brought into the read side over two read ticks.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_gray_s1 <= DCQ_PTR_ZERO;
            wr_gray_s2 <= DCQ_PTR_ZERO;
        end else if (rd_tick) begin
            wr_gray_s1 <= wr_gray;
            wr_gray_s2 <= wr_gray_s1;
        end
    end

    // Empty flags see a read at once but a write only after the crossing.
    always_ff @(posedge clk_sys) begin
        if (rst || read_pointer_reset) begin
            empty        <= 1'b1;
            almost_empty <= 1'b1;
        end else if (rd_tick) begin
            empty        <= (next_rd_level == DCQ_PTR_ZERO);
            almost_empty <= (next_rd_level < ae_thr_eff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Output data.

    // Staging depends on mode; flags above never look at it, so their timing
    // is the same in every mode. The gated mode trades a stall for power.
    always_ff @(posedge clk_sys) begin
        if (rst || read_pointer_reset) begin
            out_stage <= '0;
            read_data <= '0;
        end else begin
            unique case (out_mode)
                DCQ_OUT_DIRECT: begin
                    if (rd_ok) begin
                        read_data <= mem_q;
                    end
                end
                DCQ_OUT_REG: begin
                    if (rd_ok) begin
                        out_stage <= mem_q;
                    end
                    if (rd_tick) begin
                        read_data <= out_stage;
                    end
                end
                DCQ_OUT_REG_EN: begin
                    if (rd_ok) begin
                        out_stage <= mem_q;
                    end
                    if (rd_tick && read_enable) begin
                        read_data <= out_stage;
                    end
                end
                default: begin
                    if (rd_ok) begin
                        read_data <= mem_q;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register port and interrupts.

    // Configuration registers written by software.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_mode   <= DCQ_OUT_DIRECT;
            ae_thr     <= DCQ_AE_RESET;
            af_thr     <= DCQ_AF_RESET;
            irq_enable <= '0;
        end else if (reg_req.wr) begin
            unique case (reg_req.addr)
                DCQ_REG_CTRL:       out_mode   <= dcq_out_mode_e'(reg_req.wdata[1:0]);
                DCQ_REG_AE_THR:     ae_thr     <= reg_req.wdata[DCQ_PTR_W-1:0];
                DCQ_REG_AF_THR:     af_thr     <= reg_req.wdata[DCQ_PTR_W-1:0];
                DCQ_REG_IRQ_ENABLE: irq_enable <= reg_req.wdata[DCQ_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Events: full reached, empty reached, write refused, read refused.
    always_comb begin
        irq_event                = '0;
        irq_event[DCQ_IRQ_FULL]  = wr_tick & ~full & (next_wr_level == DCQ_FULL_LEVEL);
        irq_event[DCQ_IRQ_EMPTY] = rd_tick & ~empty & (next_rd_level == DCQ_PTR_ZERO);
        irq_event[DCQ_IRQ_OVER]  = wr_tick & write_enable & full;
        irq_event[DCQ_IRQ_UNDER] = rd_tick & read_enable & empty;
    end

    assign irq_clear = (reg_req.wr && reg_req.addr == DCQ_REG_IRQ_CLEAR) ?
                       reg_req.wdata[DCQ_IRQ_W-1:0] : '0;

    // Sticky status; an event in the clearing cycle wins over the clear.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            irq        <= |(irq_status & irq_enable);
        end
    end

    // Read data stand for the single cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                DCQ_REG_CTRL:       reg_rdata <= {30'h0000_0000, out_mode};
                DCQ_REG_AE_THR:     reg_rdata <= {22'h00_0000, ae_thr};
                DCQ_REG_AF_THR:     reg_rdata <= {22'h00_0000, af_thr};
                DCQ_REG_FLAGS:      reg_rdata <= {28'h000_0000, full, almost_full,
                                                  almost_empty, empty};
                DCQ_REG_LEVEL:      reg_rdata <= {6'h00, wr_ptr - rd_seen_bin,
                                                  6'h00, wr_seen_bin - rd_ptr};
                DCQ_REG_IRQ_STATUS: reg_rdata <= {28'h000_0000, irq_status};
                DCQ_REG_IRQ_ENABLE: reg_rdata <= {28'h000_0000, irq_enable};
                default:            reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_full_now;
        wr_ok && (next_wr_level == DCQ_FULL_LEVEL) |=> full && almost_full;
    endproperty
    a_full_now: assert property (p_full_now) else $error("full late");

    property p_drop_full;
        full && wr_tick |=> $stable(wr_ptr);
    endproperty
    a_drop_full: assert property (p_drop_full) else $error("write taken while full");

    // Staged modes may still hand out a word taken before empty rose.
    property p_drop_empty;
        empty && rd_tick && !read_pointer_reset |=>
            $stable(rd_ptr) && $stable(out_stage) &&
            (out_mode == DCQ_OUT_REG || out_mode == DCQ_OUT_REG_EN || $stable(read_data));
    endproperty
    a_drop_empty: assert property (p_drop_empty) else $error("read taken while empty");

    property p_reset_flags;
        @(posedge clk_sys) $fell(rst) |-> empty && almost_empty && !full && !almost_full;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("bad flags after reset");

    property p_empty_lag;
        empty && wr_ok && (wr_seen_bin == rd_ptr) && !read_pointer_reset |=> empty;
    endproperty
    a_empty_lag: assert property (p_empty_lag) else $error("empty fell too soon");

    property p_full_lag;
        full && rd_ok && ((wr_ptr - rd_seen_bin) == DCQ_FULL_LEVEL) |=> full;
    endproperty
    a_full_lag: assert property (p_full_lag) else $error("full fell too soon");

    property p_direct_data;
        out_mode == DCQ_OUT_DIRECT && rd_ok && !read_pointer_reset |=>
            read_data == $past(mem_q);
    endproperty
    a_direct_data: assert property (p_direct_data) else $error("direct data wrong");

    property p_gated_hold;
        out_mode == DCQ_OUT_REG_EN && !read_enable && !read_pointer_reset |=>
            $stable(read_data);
    endproperty
    a_gated_hold: assert property (p_gated_hold) else $error("gated output moved");

    property p_full_domain;
        !wr_tick |=> $stable(full) && $stable(almost_full);
    endproperty
    a_full_domain: assert property (p_full_domain) else $error("full off write tick");

    property p_irq_level;
        |(irq_status & irq_enable) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt missing");

endmodule

// *** include/dcq_pkg.sv ***
// Shared constants, types and helpers for the dual clock queue.
// Assumes one system clock; both queue clocks arrive as sampled inputs.
package dcq_pkg;

    // Storage geometry, fixed at 512 words of 18 bits.
    localparam int unsigned DCQ_DATA_W = 18;
    localparam int unsigned DCQ_ADDR_W = 9;
    localparam int unsigned DCQ_PTR_W  = 10;

    // Fill levels and threshold limits.
    localparam logic [DCQ_PTR_W-1:0] DCQ_PTR_ZERO   = 10'h000;
    localparam logic [DCQ_PTR_W-1:0] DCQ_PTR_ONE    = 10'h001;
    localparam logic [DCQ_PTR_W-1:0] DCQ_FULL_LEVEL = 10'h200;
    localparam logic [DCQ_PTR_W-1:0] DCQ_THR_MIN    = 10'h001;
    localparam logic [DCQ_PTR_W-1:0] DCQ_THR_MAX    = 10'h1FF;
    localparam logic [DCQ_PTR_W-1:0] DCQ_AE_RESET   = 10'h003;
    localparam logic [DCQ_PTR_W-1:0] DCQ_AF_RESET   = 10'h1FE;

    // Register offsets on the plain register port.
    localparam logic [7:0] DCQ_REG_CTRL       = 8'h00;
    localparam logic [7:0] DCQ_REG_AE_THR     = 8'h04;
    localparam logic [7:0] DCQ_REG_AF_THR     = 8'h08;
    localparam logic [7:0] DCQ_REG_FLAGS      = 8'h0C;
    localparam logic [7:0] DCQ_REG_LEVEL      = 8'h10;
    localparam logic [7:0] DCQ_REG_IRQ_STATUS = 8'h14;
    localparam logic [7:0] DCQ_REG_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] DCQ_REG_IRQ_CLEAR  = 8'h1C;

    // Field positions of the flag register, the level register and the interrupt registers.
    localparam int unsigned DCQ_FLAG_EMPTY  = 0;
    localparam int unsigned DCQ_FLAG_AEMPTY = 1;
    localparam int unsigned DCQ_FLAG_AFULL  = 2;
    localparam int unsigned DCQ_FLAG_FULL   = 3;
    localparam int unsigned DCQ_IRQ_W       = 4;
    localparam int unsigned DCQ_IRQ_FULL    = 0;
    localparam int unsigned DCQ_IRQ_EMPTY   = 1;
    localparam int unsigned DCQ_IRQ_OVER    = 2;
    localparam int unsigned DCQ_IRQ_UNDER   = 3;
    localparam int unsigned DCQ_LVL_WR_POS  = 16;

    // Output data staging modes; code 2'b11 is illegal and acts as direct.
    typedef enum logic [1:0] {
        DCQ_OUT_DIRECT = 2'b00,
        DCQ_OUT_REG    = 2'b01,
        DCQ_OUT_REG_EN = 2'b10
    } dcq_out_mode_e;

    // One request on the register port.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dcq_reg_req_s;

    // Gray code back to binary.
    function automatic logic [DCQ_PTR_W-1:0] dcq_gray2bin(input logic [DCQ_PTR_W-1:0] g);
        logic [DCQ_PTR_W-1:0] b;
        b[DCQ_PTR_W-1] = g[DCQ_PTR_W-1];
        for (int i = DCQ_PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// *** hw/dcq_ram.sv ***
// Storage array of the dual clock queue: one write port, one read port.
// Assumes the caller gates writes; the array is never cleared by reset.
`timescale 1ns/100ps
module dcq_ram
    import dcq_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  wr_en,
    input  wire logic [DCQ_ADDR_W-1:0] wr_addr,
    input  wire logic [DCQ_DATA_W-1:0] wr_data,
    input  wire logic [DCQ_ADDR_W-1:0] rd_addr,
    output logic      [DCQ_DATA_W-1:0] rd_data
);

    logic [DCQ_DATA_W-1:0] mem [2**DCQ_ADDR_W];

    // Write port; no reset so stored words survive a queue reset.
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read port is combinational; the caller registers the word it takes.
    assign rd_data = mem[rd_addr];

endmodule

// *** testbench/dcq_user_model.sv ***
// Partner model: writer and reader user logic on the two queue clock sides.
// Assumes clk_sys runs free; both queue clocks are divided down from it.
`timescale 1ns/100ps
module dcq_user_model
    import dcq_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  wr_on,
    input  wire logic                  rd_on,
    output logic                       write_side_clock,
    output logic                       read_side_clock,
    output logic                       write_enable,
    output logic      [DCQ_DATA_W-1:0] write_data,
    output logic                       read_enable
);
    logic [1:0] wcnt = 2'h0;
    logic [2:0] rcnt = 3'h0;

    // Everything starts idle so the queue sees defined levels at time zero.
    initial begin
        {write_side_clock, read_side_clock, write_enable, read_enable} = 4'h0;
        write_data = '0;
    end

    ////////////////////////////////////////
    // Write clock of four cycles; enable and word stand for the tick cycle only.
    // Outside a tick the data toggles, so a stale word is never taken for a new one.
    always @(posedge clk_sys) begin
        wcnt <= wcnt + 2'h1;
        write_side_clock <= (wcnt == 2'h1) || (wcnt == 2'h2);
        write_enable <= wr_on && (wcnt == 2'h1);
        write_data <= (wcnt == 2'h1) ? DCQ_DATA_W'($urandom) : ~write_data;
    end

    // Read clock of six cycles; the reader stalls at random, which the gated mode must survive.
    always @(posedge clk_sys) begin
        rcnt <= (rcnt == 3'h5) ? 3'h0 : rcnt + 3'h1;
        read_side_clock <= (rcnt >= 3'h1) && (rcnt <= 3'h3);
        read_enable <= rd_on && (rcnt == 3'h1) && (($urandom & 3) != 0);
    end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the dual clock queue: fill, drain and register traffic.
// Assumes the partner model makes both queue clocks from clk_sys.
`timescale 1ns/100ps
module testbench;
    import dcq_pkg::*;
    logic                  clk_sys = 1'b0;
    logic                  rst = 1'b1;
    logic                  wr_on = 1'b0;
    logic                  rd_on = 1'b0;
    logic                  wclk, rclk, we, re, empty, almost_empty, almost_full, full, irq;
    logic [DCQ_DATA_W-1:0] wdat, rdat;
    logic [31:0]           reg_rdata;
    dcq_reg_req_s          reg_req = '0;
    logic [DCQ_DATA_W-1:0] expq[$];
    logic [31:0]           rexp[$], rmask[$];
    int                    miscompares = 0;
    int                    compares = 0;
    int                    lvl = 0;
    int                    offers = 0;
    int                    wticks = 0;
    int                    mode = 0;
    bit                    fill_chk, drain_chk;
    int                    nw [4] = '{514, 20, 20, 2};
    logic [39:0]           rtab [9] = '{{DCQ_REG_CTRL, 32'h0}, {DCQ_REG_AE_THR, 32'h3},
        {DCQ_REG_AF_THR, 32'h1FE}, {DCQ_REG_FLAGS, 32'h3}, {DCQ_REG_LEVEL, 32'h0},
        {DCQ_REG_IRQ_ENABLE, 32'h0}, {DCQ_REG_IRQ_CLEAR, 32'h0}, {8'h20, 32'h0}, {8'hFC, 32'h0}};

    dcq_user_model dcq_user_model_i (
        .clk_sys(clk_sys), .wr_on(wr_on), .rd_on(rd_on),
        .write_side_clock(wclk), .read_side_clock(rclk), .write_enable(we),
        .write_data(wdat), .read_enable(re));
    // The read pointer reset follows the global reset, the only safe pairing.
    dcq_dual_clock_queue dcq_dual_clock_queue_i (
        .clk_sys(clk_sys), .rst(rst), .read_pointer_reset(rst),
        .write_side_clock(wclk), .read_side_clock(rclk), .write_enable(we),
        .write_data(wdat), .read_enable(re), .read_data(rdat), .empty(empty),
        .almost_empty(almost_empty), .almost_full(almost_full), .full(full),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));

    always #25 clk_sys = ~clk_sys;

    ////////////////////////////////////////
    // Compare tasks, one for each kind of result.
    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: flag or bit", $time);
        end
    endtask
    task automatic cmp_word(input logic [DCQ_DATA_W-1:0] got, input logic [DCQ_DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: read word %h, due %h", $time, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        compares++;
        if ((got & m) !== exp) begin
            miscompares++;
            $display("wrong value at %0t: register read %h", $time, got);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // A wait that runs out is a failure in its own right.
    task automatic bound(input int i, input int n);
        if (i >= n) begin
            miscompares++;
            $display("wrong value at %0t: wait ran out", $time);
            finish_test();
        end
    endtask

    ////////////////////////////////////////
    // Register port cycles; each is entered just after a rising edge.
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rexp.push_back(e);
        rmask.push_back(m);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Offers n words with the reader idle, then lets the flags settle.
    task automatic fill(input int n);
        int i;
        int o;
        o = offers;
        fill_chk = 1'b1;
        wr_on <= 1'b1;
        for (i = 0; i < 8 * n + 40 && offers - o < n; i++) @(posedge clk_sys);
        wr_on <= 1'b0;
        bound(i, 8 * n + 40);
        repeat (30) @(posedge clk_sys);
        fill_chk = 1'b0;
    endtask
    // Reads until empty, then keeps reading so staged words and underflow show.
    task automatic drain();
        int i;
        drain_chk = 1'b1;
        rd_on <= 1'b1;
        for (i = 0; i < 6000 && !(lvl == 0 && empty === 1'b1); i++) @(posedge clk_sys);
        bound(i, 6000);
        repeat (40) @(posedge clk_sys);
        rd_on <= 1'b0;
        drain_chk = 1'b0;
        cmp_bit(expq.size() == 0, 1'b1);
    endtask

    ////////////////////////////////////////
    // Write side: notes each accepted word; the bench's own level decides acceptance.
    always @(posedge clk_sys) begin : wr_mon
        bit wd;
        bit fchk;
        bit e1;
        if (fchk) begin
            cmp_bit(almost_full, lvl >= int'(DCQ_AF_RESET));
            cmp_bit(full, lvl == int'(DCQ_FULL_LEVEL));
        end
        if (e1) cmp_bit(empty, 1'b1);
        fchk = 1'b0;
        e1 = 1'b0;
        if (!rst && wclk && !wd) begin
            wticks++;
            if (we) begin
                offers++;
                fchk = fill_chk;
                if (lvl < int'(DCQ_FULL_LEVEL)) begin
                    expq.push_back(wdat);
                    lvl++;
                    e1 = (lvl == 1);
                end
            end
        end
        wd = wclk;
    end

    // Read side: a taken word is due at once, or at a later tick in the staged modes.
    always @(posedge clk_sys) begin : rd_mon
        bit rd, chk, dchk, pend, take, show;
        if (chk) cmp_word(rdat, expq.pop_front());
        if (dchk) begin
            cmp_bit(almost_empty, lvl < int'(DCQ_AE_RESET));
            cmp_bit(empty, lvl == 0);
        end
        chk = 1'b0;
        dchk = 1'b0;
        if (!rst && rclk && !rd) begin
            take = re && (empty === 1'b0);
            show = pend && (mode == 1 || (mode == 2 && re));
            chk = show || (take && mode != 1 && mode != 2);
            pend = take ? (mode == 1 || mode == 2) : (pend && !show);
            if (take) begin
                lvl--;
                dchk = drain_chk;
            end
        end
        rd = rclk;
    end

    // Register reads: the answer stands only in the cycle after the strobe.
    always @(posedge clk_sys) begin : reg_mon
        bit rdd;
        if (rdd) cmp_reg(reg_rdata, rexp.pop_front(), rmask.pop_front());
        rdd = reg_req.rd;
    end

    ////////////////////////////////////////
    // Main sequence: reset, register defaults, one fill and drain per output mode.
    initial begin
        int i;
        int k;
        int w0;
        void'($urandom(23301));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        cmp_bit(empty & almost_empty & !full & !almost_full, 1'b1);
        foreach (rtab[j]) reg_rd(rtab[j][39:32], rtab[j][31:0], 32'hFFFF_FFFF);
        reg_wr(DCQ_REG_IRQ_ENABLE, 32'h1);
        for (k = 0; k < 4; k++) begin
            mode = k;
            reg_wr(DCQ_REG_CTRL, 32'(k));
            fill(nw[k]);
            cmp_bit(empty, 1'b0);
            cmp_bit(almost_empty, nw[k] < 3);
            if (k == 0) begin
                cmp_bit(irq, 1'b1);
                reg_rd(DCQ_REG_IRQ_STATUS, 32'h5, 32'h5);
                reg_rd(DCQ_REG_LEVEL, 32'h0200_0200, 32'h03FF_03FF);
                reg_wr(DCQ_REG_IRQ_CLEAR, 32'hF);
                repeat (2) @(posedge clk_sys);
                cmp_bit(irq, 1'b0);
                rd_on <= 1'b1;
                // Falling edges are used here so the monitors' counts are settled.
                for (i = 0; i < 100 && lvl == 512; i++) @(negedge clk_sys);
                bound(i, 100);
                w0 = wticks;
                cmp_bit(full, 1'b1);
                for (i = 0; i < 100 && full !== 1'b0; i++) @(negedge clk_sys);
                bound(i, 100);
                cmp_bit((wticks - w0) inside {[2:3]}, 1'b1);
            end
            drain();
        end
        reg_rd(DCQ_REG_IRQ_STATUS, 32'h8, 32'h8);
        reg_wr(DCQ_REG_IRQ_ENABLE, 32'h8);
        repeat (2) @(posedge clk_sys);
        cmp_bit(irq, 1'b1);
        reg_wr(DCQ_REG_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge clk_sys);
        cmp_bit(irq, 1'b0);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        cmp_bit(empty & almost_empty & !full & !almost_full, 1'b1);
        cmp_word(rdat, '0);
        finish_test();
    end
endmodule
